// >>> logic/lsc_pkg.sv
// Constants, encodings and carrier types for the lamp serial command block
package lsc_pkg;
   localparam int          CLK_MHZ        = 40;
   localparam int          PKT_LIMIT_US   = 30000;
   localparam int          REPLY_DELAY_US = 10000;
   localparam int          FOCUS_RUN_US   = 100000;
   localparam int          TMR_W          = 23;
   localparam logic [7:0]  SYNC_BYTE      = 8'hFF;
   localparam logic [7:0]  ADDR_MIN       = 8'h90;
   localparam logic [7:0]  ADDR_MAX       = 8'hA8;
   localparam logic [7:0]  CMD_FOCUS      = 8'h0B;
   localparam logic [7:0]  CMD_HOME       = 8'h0C;
   localparam logic [7:0]  CMD_REC        = 8'h0D;
   localparam logic [7:0]  CMD_PLAY       = 8'h0E;
   localparam logic [7:0]  CMD_STORE      = 8'h0F;
   localparam logic [7:0]  CMD_PAN_CW     = 8'h14;
   localparam logic [7:0]  CMD_PAN_ACW    = 8'h15;
   localparam logic [7:0]  CMD_TILT_DN    = 8'h16;
   localparam logic [7:0]  CMD_TILT_UP    = 8'h17;
   localparam logic [7:0]  CMD_PAN_GOTO   = 8'h18;
   localparam logic [7:0]  CMD_TILT_GOTO  = 8'h19;
   localparam logic [7:0]  CMD_LAMP_ON    = 8'h1A;
   localparam logic [7:0]  CMD_LAMP_OFF   = 8'h1B;
   localparam logic [7:0]  CMD_STATUS     = 8'h1E;
   localparam logic [7:0]  CSUM_MASK      = 8'h7F;
   localparam logic [3:0]  LEN_SHORT      = 4'h4;
   localparam logic [3:0]  LEN_JOG        = 4'h5;
   localparam logic [3:0]  LEN_POS        = 4'h6;
   localparam logic [3:0]  REPLY_LEN      = 4'hD;
   localparam logic [3:0]  UART_BITS      = 4'hA;
   localparam logic [3:0]  UART_STOP_IDX  = 4'h9;
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_BAUD       = 8'h04;
   localparam logic [7:0]  REG_STAT       = 8'h08;
   localparam logic [7:0]  REG_ERRS       = 8'h0C;
   localparam logic [7:0]  REG_HOME       = 8'h10;
   localparam int          CTRL_CHK_BIT   = 0;
   localparam logic        CTRL_CHK_RST   = 1'b1;
   localparam logic [15:0] BAUD_RST       = 16'h1047;
   localparam logic [15:0] BAUD_MIN       = 16'h0004;

   typedef enum logic [1:0] {PH_RX, PH_WAIT, PH_TX} lsc_phase_t;
   typedef enum logic [3:0] {OP_NONE, OP_FOCUS, OP_HOME, OP_STORE, OP_REC, OP_PLAY,
                             OP_PAN_CW, OP_PAN_ACW, OP_TILT_DN, OP_TILT_UP,
                             OP_PAN_GOTO, OP_TILT_GOTO, OP_LAMP_ON, OP_LAMP_OFF,
                             OP_STATUS} lsc_op_t;

   // Command event towards the lamp network side
   typedef struct packed {
      logic       valid;
      logic [4:0] lamp;
      lsc_op_t    op;
      logic [11:0] arg;
   } lsc_cmd_t;

   // Live state of the addressed lamp, reported back in the reply
   typedef struct packed {
      logic [11:0] pan_pos;
      logic [11:0] tilt_pos;
      logic [6:0]  flags;
      logic [7:0]  focus;
      logic [4:0]  fault1;
      logic [3:0]  fault2;
      logic [7:0]  sw_ver;
      logic [7:0]  type_no;
   } lsc_lamp_stat_t;
endpackage

// >>> logic/lsc_serial_cmd.sv
// Serial command interpreter with AHB-Lite control registers
`timescale 1ns/1ps
module lsc_serial_cmd
   import lsc_pkg::*;
#(
   parameter int PKT_LIMIT_CYC   = PKT_LIMIT_US * CLK_MHZ,
   parameter int REPLY_DELAY_CYC = REPLY_DELAY_US * CLK_MHZ,
   parameter int FOCUS_RUN_CYC   = FOCUS_RUN_US * CLK_MHZ
)(
   input  wire logic           clk,
   input  wire logic           reset,
   input  wire logic           hsel,
   input  wire logic [31:0]    haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire logic [31:0]    hwdata,
   input  wire logic           hready,
   output logic                hreadyout,
   output logic                hresp,
   output logic [31:0]         hrdata,
   input  wire logic           ser_rx,
   output logic                ser_tx,
   output logic                ser_tx_oe,
   input  wire lsc_lamp_stat_t lamp_stat,
   output lsc_cmd_t            cmd,
   output logic                focus_run,
   output logic [11:0]         home_pan,
   output logic [11:0]         home_tilt
);

   typedef struct packed {
      logic            rx_s1;
      logic            rx_s2;
      logic            rx_busy;
      logic [15:0]     rx_cnt;
      logic [3:0]      rx_bit;
      logic [7:0]      rx_sh;
      lsc_phase_t      phase;
      logic [3:0]      idx;
      logic [3:0]      len;
      logic [7:0]      sum;
      logic [7:0]      addr;
      logic [7:0]      code;
      logic [7:0]      d0;
      logic [7:0]      d1;
      logic [TMR_W-1:0] pkt_tmr;
      logic [TMR_W-1:0] wait_tmr;
      logic [TMR_W-1:0] focus_tmr;
      logic            tx_busy;
      logic [15:0]     tx_cnt;
      logic [3:0]      tx_bit;
      logic [9:0]      tx_sh;
      logic [3:0]      tx_idx;
      logic [7:0]      tx_sum;
      logic            tx_line;
      lsc_lamp_stat_t  snap;
      lsc_cmd_t        ev;
      logic [11:0]     home_pan;
      logic [11:0]     home_tilt;
      logic            chk_en;
      logic [15:0]     baud;
      logic [7:0]      n_csum;
      logic [7:0]      n_addr;
      logic [7:0]      n_code;
      logic [7:0]      n_time;
      lsc_op_t         last_op;
      logic            wr_pend;
      logic [7:0]      wr_addr;
      logic [31:0]     rdata;
   } st_t;

   localparam logic [TMR_W-1:0] PKT_LIM   = TMR_W'(PKT_LIMIT_CYC);
   localparam logic [TMR_W-1:0] REPLY_DLY = TMR_W'(REPLY_DELAY_CYC);
   localparam logic [TMR_W-1:0] FOCUS_LEN = TMR_W'(FOCUS_RUN_CYC);

   localparam st_t ST_RST = '{
      rx_s1: 1'b1, rx_s2: 1'b1, rx_busy: 1'b0, rx_cnt: '0, rx_bit: '0, rx_sh: '0,
      phase: PH_RX, idx: '0, len: '0, sum: '0, addr: '0, code: '0, d0: '0, d1: '0,
      pkt_tmr: '0, wait_tmr: '0, focus_tmr: '0,
      tx_busy: 1'b0, tx_cnt: '0, tx_bit: '0, tx_sh: '1, tx_idx: '0, tx_sum: '0,
      tx_line: 1'b1, snap: '0, ev: '0, home_pan: '0, home_tilt: '0,
      chk_en: CTRL_CHK_RST, baud: BAUD_RST, n_csum: '0, n_addr: '0, n_code: '0,
      n_time: '0, last_op: OP_NONE, wr_pend: 1'b0, wr_addr: '0, rdata: '0};

   st_t q;
   st_t d;

   // Expected packet length from command code, zero when unknown
   function automatic logic [3:0] cmd_len(input logic [7:0] c);
      logic [3:0] n;
      n = '0;
      unique case (c)
         CMD_FOCUS, CMD_HOME, CMD_REC, CMD_PLAY, CMD_STORE,
         CMD_LAMP_ON, CMD_LAMP_OFF, CMD_STATUS:          n = LEN_SHORT;
         CMD_PAN_CW, CMD_PAN_ACW, CMD_TILT_DN, CMD_TILT_UP: n = LEN_JOG;
         CMD_PAN_GOTO, CMD_TILT_GOTO:                    n = LEN_POS;
         default:                                        n = '0;
      endcase
      return n;
   endfunction

   // Reply byte by position, checksum last
   function automatic logic [7:0] reply_byte(input logic [3:0] i, input lsc_lamp_stat_t s,
                                             input logic [7:0] a, input logic [7:0] sm);
      logic [7:0] b;
      b = '0;
      unique case (i)
         4'h0: b = SYNC_BYTE;
         4'h1: b = a;
         4'h2: b = {1'b0, s.pan_pos[6:0]};
         4'h3: b = {3'b000, s.pan_pos[11:7]};
         4'h4: b = {1'b0, s.tilt_pos[6:0]};
         4'h5: b = {3'b000, s.tilt_pos[11:7]};
         4'h6: b = {1'b0, s.flags};
         4'h7: b = s.focus;
         4'h8: b = {3'b000, s.fault1};
         4'h9: b = {4'h0, s.fault2};
         4'hA: b = s.sw_ver;
         4'hB: b = s.type_no;
         default: b = sm & CSUM_MASK;
      endcase
      return b;
   endfunction

   always_comb begin
      logic        rx_stb;
      logic [7:0]  rx_byte;
      logic [3:0]  n;
      logic [7:0]  csum;
      logic        adr_ok;
      logic        aph;
      logic [7:0]  b;
      rx_stb  = 1'b0;
      rx_byte = '0;
      n       = '0;
      csum    = '0;
      adr_ok  = 1'b0;
      aph     = 1'b0;
      b       = '0;
      d       = q;
      d.ev.valid = 1'b0;

      // Receiver: two-flop sync then mid-bit sampling
      // start, eight LSB-first, stop
      d.rx_s1 = ser_rx;
      d.rx_s2 = q.rx_s1;
      if (!q.rx_busy) begin
         if (!q.rx_s2) begin
            d.rx_busy = 1'b1;
            d.rx_cnt  = {1'b0, q.baud[15:1]};
            d.rx_bit  = '0;
         end
      end else if (q.rx_cnt != '0) begin
         d.rx_cnt = q.rx_cnt - 16'h0001;
      end else begin
         d.rx_cnt = q.baud - 16'h0001;
         d.rx_bit = q.rx_bit + 4'h1;
         if (q.rx_bit == '0) begin
            d.rx_busy = !q.rx_s2;           // False start is dropped
         end else if (q.rx_bit == UART_STOP_IDX) begin
            d.rx_busy = 1'b0;
            rx_stb    = q.rx_s2;            // Framing error drops the byte
            rx_byte   = q.rx_sh;
         end else begin
            d.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
         end
      end

      // Packet timer, runs while a packet is open
      // reject over-long packets
      if (q.idx != '0) begin
         d.pkt_tmr = q.pkt_tmr + TMR_W'(1);
         if (q.pkt_tmr >= PKT_LIM) begin
            d.idx    = '0;
            d.n_time = q.n_time + 8'h01;
         end
      end

      // Focus motor run window, ahead of the parser so a repeat reloads it
      if (q.focus_tmr != '0)
         d.focus_tmr = q.focus_tmr - TMR_W'(1);

      // Packet parser, ignores the line while answering
      if (rx_stb && q.phase == PH_RX) begin
         if (rx_byte == SYNC_BYTE) begin
            d.idx     = 4'h1;
            d.sum     = SYNC_BYTE;
            d.pkt_tmr = '0;
         end else if (q.idx == 4'h1) begin
            adr_ok = rx_byte >= ADDR_MIN && rx_byte <= ADDR_MAX;
            d.addr = rx_byte;
            d.sum  = q.sum + rx_byte;
            d.idx  = adr_ok ? 4'h2 : 4'h0;
            if (!adr_ok)
               d.n_addr = q.n_addr + 8'h01;
         end else if (q.idx == 4'h2) begin
            n      = cmd_len(rx_byte);
            d.code = rx_byte;
            d.len  = n;
            d.sum  = q.sum + rx_byte;
            d.idx  = (n != '0) ? 4'h3 : 4'h0;
            if (n == '0)
               d.n_code = q.n_code + 8'h01;
         end else if (q.idx != '0 && q.idx < q.len - 4'h1) begin
            if (q.idx == 4'h3)
               d.d0 = rx_byte;
            else
               d.d1 = rx_byte;
            d.sum = q.sum + rx_byte;
            d.idx = q.idx + 4'h1;
         end else if (q.idx != '0) begin
            d.idx = '0;
            csum  = q.sum & CSUM_MASK;
            if (q.chk_en && rx_byte != csum) begin
               d.n_csum = q.n_csum + 8'h01;
            end else begin
               d.ev.valid = 1'b1;
               d.ev.lamp  = 5'(q.addr - ADDR_MIN);
               d.ev.arg   = '0;
               unique case (q.code)
                  CMD_FOCUS: begin
                     d.ev.op     = OP_FOCUS;
                     d.focus_tmr = FOCUS_LEN;
                  end
                  CMD_HOME: begin
                     d.ev.op  = OP_HOME;
                     d.ev.arg = q.home_pan;
                  end
                  CMD_STORE: begin
                     d.ev.op      = OP_STORE;
                     d.home_pan   = lamp_stat.pan_pos;
                     d.home_tilt  = lamp_stat.tilt_pos;
                  end
                  CMD_REC:  d.ev.op = OP_REC;
                  CMD_PLAY: d.ev.op = OP_PLAY;
                  CMD_LAMP_ON:  d.ev.op = OP_LAMP_ON;
                  CMD_LAMP_OFF: d.ev.op = OP_LAMP_OFF;
                  CMD_PAN_CW: begin
                     d.ev.op  = OP_PAN_CW;
                     d.ev.arg = {5'h00, q.d0[6:0]};
                  end
                  CMD_PAN_ACW: begin
                     d.ev.op  = OP_PAN_ACW;
                     d.ev.arg = {5'h00, q.d0[6:0]};
                  end
                  CMD_TILT_DN: begin
                     d.ev.op  = OP_TILT_DN;
                     d.ev.arg = {5'h00, q.d0[6:0]};
                  end
                  CMD_TILT_UP: begin
                     d.ev.op  = OP_TILT_UP;
                     d.ev.arg = {5'h00, q.d0[6:0]};
                  end
                  // low seven bits first, high five last
                  // sign kept at high-part weight 0x08
                  CMD_PAN_GOTO: begin
                     d.ev.op  = OP_PAN_GOTO;
                     d.ev.arg = {q.d1[4:0], q.d0[6:0]};
                  end
                  CMD_TILT_GOTO: begin
                     d.ev.op  = OP_TILT_GOTO;
                     d.ev.arg = {q.d1[4:0], q.d0[6:0]};
                  end
                  default: begin
                     d.ev.op     = OP_STATUS;
                     d.phase     = PH_WAIT;
                     d.wait_tmr  = REPLY_DLY;
                  end
               endcase
               d.last_op = d.ev.op;
            end
         end
      end

      // Turnaround wait, then load reply
      // delay inside 2-30 ms
      if (q.phase == PH_WAIT) begin
         if (q.wait_tmr != '0) begin
            d.wait_tmr = q.wait_tmr - TMR_W'(1);
         end else begin
            d.phase  = PH_TX;
            d.snap   = lamp_stat;
            d.tx_idx = '0;
            d.tx_sum = '0;
         end
      end

      // Reply transmitter, one frame per byte
      // fixed thirteen-byte order
      if (q.phase == PH_TX && !q.tx_busy) begin
         if (q.tx_idx == REPLY_LEN) begin
            d.phase = PH_RX;
         end else begin
            b         = reply_byte(q.tx_idx, q.snap, q.addr, q.tx_sum);
            d.tx_sum  = q.tx_sum + b;
            d.tx_idx  = q.tx_idx + 4'h1;
            d.tx_sh   = {1'b1, b, 1'b0};
            d.tx_busy = 1'b1;
            d.tx_bit  = '0;
            d.tx_cnt  = q.baud - 16'h0001;
         end
      end else if (q.tx_busy) begin
         if (q.tx_cnt != '0) begin
            d.tx_cnt = q.tx_cnt - 16'h0001;
         end else begin
            d.tx_cnt = q.baud - 16'h0001;
            d.tx_sh  = {1'b1, q.tx_sh[9:1]};
            d.tx_bit = q.tx_bit + 4'h1;
            if (q.tx_bit == UART_BITS - 4'h1)
               d.tx_busy = 1'b0;
         end
      end
      d.tx_line = (q.phase == PH_TX && q.tx_busy) ? q.tx_sh[0] : 1'b1;

      // AHB-Lite slave: data phase writes, read data set up early
      aph = hsel && hready && htrans[1];
      if (q.wr_pend) begin
         unique case (q.wr_addr)
            REG_CTRL: d.chk_en = hwdata[CTRL_CHK_BIT];
            REG_BAUD: d.baud   = (hwdata[15:0] < BAUD_MIN) ? BAUD_MIN : hwdata[15:0];
            default:  d.chk_en = q.chk_en;
         endcase
      end
      d.wr_pend = aph && hwrite;
      d.wr_addr = {haddr[7:2], 2'b00};
      if (aph && !hwrite) begin
         unique case ({haddr[7:2], 2'b00})
            REG_CTRL: d.rdata = {31'h00000000, q.chk_en};
            REG_BAUD: d.rdata = {16'h0000, q.baud};
            REG_STAT: d.rdata = {16'h0000, 4'(q.last_op), 4'(q.idx), 2'b00,
                                 q.phase, q.tx_busy, 2'b00, focus_run};
            REG_ERRS: d.rdata = {q.n_time, q.n_code, q.n_addr, q.n_csum};
            REG_HOME: d.rdata = {4'h0, q.home_tilt, 4'h0, q.home_pan};
            default:  d.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset)
         q <= ST_RST;
      else
         q <= d;
   end

   // Outputs
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.rdata;
   assign ser_tx    = q.tx_line;
   assign ser_tx_oe = q.phase == PH_TX;
   assign cmd       = q.ev;
   assign focus_run = q.focus_tmr != '0;
   assign home_pan  = q.home_pan;
   assign home_tilt = q.home_tilt;

endmodule

// >>> testbench/lsc_serial_cmd_asserts.sv
// Port checker for the lamp serial command block
`timescale 1ns/1ps
module lsc_serial_cmd_asserts
   import lsc_pkg::*;
#(
   parameter int REPLY_DELAY_CYC = 100,
   parameter int FOCUS_RUN_CYC   = 50
)(
   input wire logic           clk,
   input wire logic           reset,
   input wire logic           ser_tx,
   input wire logic           ser_tx_oe,
   input wire lsc_cmd_t       cmd,
   input wire logic           focus_run,
   input wire logic [11:0]    home_pan,
   input wire logic [11:0]    home_tilt,
   input wire lsc_lamp_stat_t lamp_stat
);
   int   wait_q;
   int   focus_q;
   logic st_ev;
   logic fo_ev;
   logic sv_ev;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Event decodes
   assign st_ev = cmd.valid && cmd.op == OP_STATUS;
   assign fo_ev = cmd.valid && cmd.op == OP_FOCUS;
   assign sv_ev = cmd.valid && cmd.op == OP_STORE;
   // Cycles since status request and since focus; saturate
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_q  <= 0;
         focus_q <= 0;
      end else begin
         if (st_ev) begin
            wait_q <= 1;
         end else if (ser_tx_oe) begin
            wait_q <= 0;
         end else if (wait_q != 0 && wait_q < 100000) begin
            wait_q <= wait_q + 1;
         end
         if (fo_ev) begin
            focus_q <= 1;
         end else if (focus_q != 0 && focus_q < 100000) begin
            focus_q <= focus_q + 1;
         end
      end
   end
   property p_tx_idle; !ser_tx_oe |-> ser_tx; endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("line not idle");
   property p_oe_cause;
      $rose(ser_tx_oe) |-> wait_q >= REPLY_DELAY_CYC && wait_q <= REPLY_DELAY_CYC + 2;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("reply start wrong");
   property p_oe_wait; st_ev |=> !ser_tx_oe [*8]; endproperty
   a_oe_wait: assert property (p_oe_wait) else $error("no turnaround");
   property p_tx_end; $fell(ser_tx_oe) |-> ser_tx && $past(ser_tx); endproperty
   a_tx_end: assert property (p_tx_end) else $error("released mid frame");
   property p_pulse; cmd.valid |=> !cmd.valid; endproperty
   a_pulse: assert property (p_pulse) else $error("event too long");
   property p_lamp; cmd.valid |-> cmd.lamp <= 5'h18; endproperty
   a_lamp: assert property (p_lamp) else $error("lamp out of range");
   property p_op; cmd.valid |-> cmd.op != OP_NONE; endproperty
   a_op: assert property (p_op) else $error("empty event");
   property p_focus_on; fo_ev |-> ##[0:2] focus_run; endproperty
   a_focus_on: assert property (p_focus_on) else $error("focus idle");
   property p_focus_brief;
      focus_run |-> fo_ev || (focus_q != 0 && focus_q <= FOCUS_RUN_CYC + 2);
   endproperty
   a_focus_brief: assert property (p_focus_brief) else $error("focus too long");
   property p_home_arg; cmd.valid && cmd.op == OP_HOME |-> cmd.arg == home_pan; endproperty
   a_home_arg: assert property (p_home_arg) else $error("home target wrong");
   property p_home_hold;
      !$stable({home_pan, home_tilt}) |-> sv_ev || $past(sv_ev);
   endproperty
   a_home_hold: assert property (p_home_hold) else $error("home changed");
   property p_home_store;
      sv_ev |-> home_pan == $past(lamp_stat.pan_pos) && home_tilt == $past(lamp_stat.tilt_pos);
   endproperty
   a_home_store: assert property (p_home_store) else $error("home not latched");
endmodule

// >>> testbench/lsc_host_model.sv
// Host controller model: packet sender and reply receiver
`timescale 1ns/1ps
module lsc_host_model (
   input  wire logic clk,
   input  wire logic dev_tx,
   input  wire logic dev_oe,
   output logic      host_tx
);
   int         bit_cyc = 8;
   int         ferr    = 0;
   logic [7:0] rx_q [$];
   logic [7:0] rb;
   logic       line;
   initial host_tx = 1'h1;
   // start, LSB first, stop, back to back
   task send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++) begin
         host_tx <= fr[i];
         repeat (bit_cyc) @(posedge clk);
      end
   endtask
   // Released line is biased to the idle level
   assign line = dev_oe ? dev_tx : 1'h1;
   always begin
      @(posedge clk);
      if (!line) begin
         repeat (bit_cyc / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk);
            rb[i] = line;
         end
         repeat (bit_cyc) @(posedge clk);
         if (line !== 1'h1) ferr++;
         rx_q.push_back(rb);
      end
   end
endmodule

// >>> testbench/lamp_serial_command_interface_tb.sv
// Testbench for the lamp serial command block
`timescale 1ns/1ps
module lamp_serial_command_interface_tb
   import lsc_pkg::*;
;
   localparam int PKT = 1000;
   localparam logic [7:0] CODES [13] = '{CMD_FOCUS, CMD_STORE, CMD_HOME, CMD_REC, CMD_PLAY,
      CMD_PAN_CW, CMD_PAN_ACW, CMD_TILT_DN, CMD_TILT_UP, CMD_PAN_GOTO, CMD_TILT_GOTO,
      CMD_LAMP_ON, CMD_LAMP_OFF};
   localparam lsc_op_t OPS [13] = '{OP_FOCUS, OP_STORE, OP_HOME, OP_REC, OP_PLAY, OP_PAN_CW,
      OP_PAN_ACW, OP_TILT_DN, OP_TILT_UP, OP_PAN_GOTO, OP_TILT_GOTO, OP_LAMP_ON, OP_LAMP_OFF};
   logic           clk, reset, hwrite, ser_rx, hreadyout, hresp, ser_tx, ser_tx_oe;
   logic           focus_run, saw_focus;
   logic [31:0]    haddr, hwdata, hrdata, rd;
   logic [1:0]     htrans;
   logic [11:0]    home_pan, home_tilt;
   lsc_lamp_stat_t lamp_stat;
   lsc_cmd_t       cmd;
   lsc_cmd_t       ev_q [$];
   int             fails, check_count;
   int             seed = 32'hC44D;
   lsc_serial_cmd #(.PKT_LIMIT_CYC(PKT), .REPLY_DELAY_CYC(100), .FOCUS_RUN_CYC(50))
      lsc_serial_cmd_inst (.clk(clk), .reset(reset), .hsel(1'h1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ser_rx(ser_rx), .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe), .lamp_stat(lamp_stat),
      .cmd(cmd), .focus_run(focus_run), .home_pan(home_pan), .home_tilt(home_tilt));
   lsc_host_model lsc_host_model_inst (.clk(clk), .dev_tx(ser_tx), .dev_oe(ser_tx_oe),
      .host_tx(ser_rx));
   // Clock at 40 MHz
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   // Collect command events and focus activity
   always @(posedge clk) begin
      if (cmd.valid === 1'h1) ev_q.push_back(cmd);
      if (focus_run === 1'h1) saw_focus = 1'h1;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Bounded wait for the slave to take a phase
   task wait_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'h1) begin
         n++;
         if (n > 50) begin
            fails++;
            tally_and_finish;
         end
         @(posedge clk);
      end
   endtask
   // One single word transfer, read data left in rd
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask
   // Packet with length from command and additive checksum
   task send(input logic [7:0] adr, code, d0, d1, flip, input int gap);
      logic [7:0] pk [6];
      int         len, s;
      len = (code == CMD_PAN_GOTO || code == CMD_TILT_GOTO) ? 6 :
            (code >= CMD_PAN_CW && code <= CMD_TILT_UP) ? 5 : 4;
      pk = '{SYNC_BYTE, adr, code, d0, d1, 8'h00};
      s = 0;
      for (int i = 0; i < len - 1; i++) s += pk[i];
      pk[len - 1] = (s[7:0] & CSUM_MASK) ^ flip;
      ev_q.delete();
      for (int i = 0; i < len; i++) begin
         lsc_host_model_inst.send_byte(pk[i]);
         if (i == 1) repeat (gap) @(posedge clk);
      end
      // packet spacing, scaled like the time limit
      repeat (PKT * 10 / 3) @(posedge clk);
   endtask
   // Expect zero or one event within a bounded window
   task expect_ev(input int want, output lsc_cmd_t ev);
      for (int n = 0; n < 100 && ev_q.size() == 0; n++) @(posedge clk);
      check_count++;
      if (ev_q.size() != want) begin
         fails++;
         $display("unexpected at %0t: %0d events", $time, ev_q.size());
         tally_and_finish;
      end
      ev = (want != 0) ? ev_q.pop_front() : '0;
   endtask
   initial begin
      lsc_cmd_t       ev;
      lsc_lamp_stat_t ls;
      logic [7:0]     adr, d0, d1;
      logic [7:0]     ex [13];
      logic [7:0]     bad_a [4], bad_c [4], bad_f [4];
      int             s, n;
      fails = 0;
      check_count = 0;
      saw_focus = 1'h0;
      reset = 1'h1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
      lamp_stat = {$random(seed), $random(seed)};
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      ahb(1'h0, REG_CTRL, 32'h0);
      check(rd, 32'h1);
      check(hresp, 1'h0);
      ahb(1'h0, REG_HOME, 32'h0);
      check(rd, 32'h0);
      ahb(1'h1, REG_BAUD, 32'h8);
      ahb(1'h0, REG_BAUD, 32'h0);
      check(rd, 32'h8);
      ahb(1'h1, 32'h40, 32'hFFFF);
      ahb(1'h0, 32'h40, 32'h0);
      check(rd, 32'h0);
      for (int k = 0; k < 13; k++) begin
         adr = ADDR_MIN + 8'({$random(seed)} % 25);
         d0 = 8'({$random(seed)} % 128);
         d1 = 8'({$random(seed)} % 32);
         send(adr, CODES[k], d0, d1, 8'h00, 0);
         expect_ev(1, ev);
         check(ev.lamp, adr - ADDR_MIN);
         check(ev.op, OPS[k]);
         if (k >= 5 && k <= 8) check(ev.arg, d0);
         if (k >= 9 && k <= 10) check(ev.arg, {d1[4:0], d0[6:0]});
         if (k >= 9 && k <= 10) check(ev.arg[10], d1[3]);
         if (k == 1) check(focus_run, 1'h0);
         if (k == 2) check(ev.arg, lamp_stat.pan_pos);
         if (k == 2) check(home_tilt, lamp_stat.tilt_pos);
         if (k == 2) check(home_pan, lamp_stat.pan_pos);
      end
      check(saw_focus, 1'h1);
      ahb(1'h0, REG_HOME, 32'h0);
      check(rd, {4'h0, lamp_stat.tilt_pos, 4'h0, lamp_stat.pan_pos});
      bad_a = '{8'hA9, ADDR_MIN, ADDR_MIN, ADDR_MIN};
      bad_c = '{CMD_LAMP_ON, 8'h1F, CMD_LAMP_ON, CMD_LAMP_ON};
      bad_f = '{8'h00, 8'h00, 8'h01, 8'h00};
      for (int k = 0; k < 4; k++) begin
         send(bad_a[k], bad_c[k], 8'h00, 8'h00, bad_f[k], (k == 3) ? PKT + 100 : 0);
         expect_ev(0, ev);
      end
      ahb(1'h0, REG_ERRS, 32'h0);
      check(rd, 32'h01010101);
      ahb(1'h1, REG_CTRL, 32'h0);
      send(ADDR_MIN, CMD_LAMP_OFF, 8'h00, 8'h00, 8'h01, 0);
      expect_ev(1, ev);
      check(ev.op, OP_LAMP_OFF);
      ahb(1'h1, REG_CTRL, 32'h1);
      lsc_host_model_inst.send_byte(SYNC_BYTE);
      lsc_host_model_inst.send_byte(8'h91);
      send(8'h93, CMD_LAMP_ON, 8'h00, 8'h00, 8'h00, 0);
      expect_ev(1, ev);
      check(ev.lamp, 5'h3);
      check(lsc_host_model_inst.rx_q.size(), 0);
      ls = {$random(seed), $random(seed)};
      ls.focus = 8'({$random(seed)} % 101);
      lamp_stat <= ls;
      send(ADDR_MAX, CMD_STATUS, 8'h00, 8'h00, 8'h00, 0);
      expect_ev(1, ev);
      check(ev.op, OP_STATUS);
      ex = '{SYNC_BYTE, ADDR_MAX, {1'h0, ls.pan_pos[6:0]}, {3'h0, ls.pan_pos[11:7]},
             {1'h0, ls.tilt_pos[6:0]}, {3'h0, ls.tilt_pos[11:7]}, {1'h0, ls.flags},
             ls.focus, {3'h0, ls.fault1}, {4'h0, ls.fault2}, ls.sw_ver, ls.type_no, 8'h00};
      s = 0;
      for (int i = 0; i < 12; i++) s += ex[i];
      ex[12] = s[7:0] & CSUM_MASK;
      for (n = 0; n < 3000 && lsc_host_model_inst.rx_q.size() < 13; n++) @(posedge clk);
      for (n = 0; n < 20 && ser_tx_oe !== 1'h0; n++) @(posedge clk);
      check(ser_tx_oe, 1'h0);
      check(lsc_host_model_inst.rx_q.size(), 13);
      for (int i = 0; i < 13; i++) check(lsc_host_model_inst.rx_q[i], ex[i]);
      check(lsc_host_model_inst.ferr, 0);
      ahb(1'h0, REG_STAT, 32'h0);
      check(rd, {16'h0000, 4'(OP_STATUS), 12'h000});
      tally_and_finish;
   end
endmodule
bind lsc_serial_cmd lsc_serial_cmd_asserts #(.REPLY_DELAY_CYC(REPLY_DELAY_CYC),
   .FOCUS_RUN_CYC(FOCUS_RUN_CYC)) lsc_serial_cmd_asserts_inst (.clk(clk), .reset(reset),
   .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe), .cmd(cmd), .focus_run(focus_run),
   .home_pan(home_pan), .home_tilt(home_tilt), .lamp_stat(lamp_stat));
